// *** include/dmdm_defs.svh ***
`ifndef DMDM_DEFS_SVH
`define DMDM_DEFS_SVH
// Operation
// - Coil N travels as zero-based data address N minus one.
// - Holding register 4xxxx drops prefix; register N travels as address N minus one.
// - Coils hold one bit; holding registers hold one 16-bit word.
// - Coils 1-16 are command word; 1-2 preset select, 14-15 set-up select.
// - Coils 17-32 hold the 16-bit speed reference written by master.
// - Coils 33-48 present the drive status word, read only.
// - Coils 49-64 return output frequency open loop, feedback closed loop.
// - Coil 65 at zero makes parameter writes go to working RAM only.
// - Coil 65 at one commits parameter writes to non-volatile memory and RAM.
// - Command bits 3-6 request brake, coast, quick stop, freeze at zero; 7 start; 8 reset.
// - Status 33 control ready, 34 drive ready, 35 safety closed, 36 alarm, 40 warning.
// - Status 41-44, 46-48 as listed; coils 37-39 and 45 read zero.
// - Holding register 7 returns last error code of the data-object interface.
// - Holding register 9 holds array index applied to indexed parameter accesses.
// - Parameters map in steps of ten, register numbers 10 up to 49990.
// - Parameter register number equals ten times the parameter number.
// - Register 50000 takes the command word, 50010 the bus reference.
// - Register 50200 shows the status word, 50210 the main actual value.

// Coil data addresses, zero based.
`define DMDM_COIL_CMD_LAST   16'h000f
`define DMDM_COIL_REF_LAST   16'h001f
`define DMDM_COIL_STAT_LAST  16'h002f
`define DMDM_COIL_ACT_LAST   16'h003f
`define DMDM_COIL_STORE      16'h0040

// Holding register numbers as printed, decimal.
`define DMDM_REG_LAST_ERROR  17'd7
`define DMDM_REG_ARRAY_INDEX 17'd9
`define DMDM_REG_CMD_WORD    17'd50000
`define DMDM_REG_BUS_REF     17'd50010
`define DMDM_REG_STATUS      17'd50200
`define DMDM_REG_ACTUAL      17'd50210
`define DMDM_REG_PARAM_FIRST 17'd10
`define DMDM_REG_PARAM_LAST  17'd49990
`define DMDM_PARAM_STEP      17'd10

// Command word fields.
`define DMDM_CMD_PRESET_LO   0
`define DMDM_CMD_DC_BRAKE    2
`define DMDM_CMD_COAST       3
`define DMDM_CMD_QSTOP       4
`define DMDM_CMD_FREEZE      5
`define DMDM_CMD_START       6
`define DMDM_CMD_RESET       7
`define DMDM_CMD_SETUP_LO    13

// Reset values.
`define DMDM_RST_CMD_WORD    16'h0000
`define DMDM_RST_BUS_REF     16'h0000
`define DMDM_RST_INDEX       16'h0000
`define DMDM_RST_ERROR       16'h0000
`endif

// *** include/dmdm_pkg.sv ***
package dmdm_pkg;
  typedef enum logic [2:0] {
    DMDM_C_CMD, DMDM_C_REF, DMDM_C_STAT, DMDM_C_ACT, DMDM_C_STORE, DMDM_C_NONE
  } dmdm_coil_t;
  typedef enum logic [2:0] {
    DMDM_H_ERR, DMDM_H_IDX, DMDM_H_CMD, DMDM_H_REF,
    DMDM_H_STAT, DMDM_H_ACT, DMDM_H_PARAM, DMDM_H_NONE
  } dmdm_hold_t;
  typedef enum {
    DMDM_IDLE, DMDM_PARAM_WAIT
  } dmdm_state_t;
endpackage

// *** core/dmdm_map.sv ***
`timescale 1ns/1ps
`include "dmdm_defs.svh"
module dmdm_map
  import dmdm_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  input  wire logic               clk,
  input  wire logic               reset,
  input  wire logic               req_valid,
  output logic                    req_ready,
  input  wire logic               req_holding,
  input  wire logic               req_write,
  input  wire logic [ADDR_W-1:0]  req_addr,
  input  wire logic [15:0]        req_wdata,
  output logic                    resp_valid,
  output logic [15:0]             resp_rdata,
  output logic                    resp_reserved,
  input  wire logic               control_ready,
  input  wire logic               drive_ready,
  input  wire logic               safety_closed,
  input  wire logic               alarm,
  input  wire logic               warning,
  input  wire logic               at_reference,
  input  wire logic               auto_mode,
  input  wire logic               in_freq_range,
  input  wire logic               running,
  input  wire logic               voltage_warning,
  input  wire logic               current_limit,
  input  wire logic               thermal_warning,
  input  wire logic               closed_loop,
  input  wire logic [15:0]        output_frequency,
  input  wire logic [15:0]        feedback_value,
  input  wire logic               error_valid,
  input  wire logic [15:0]        error_code,
  output logic [15:0]             command_word,
  output logic [15:0]             speed_reference,
  output logic [1:0]              preset_ref_sel,
  output logic [1:0]              setup_sel,
  output logic                    dc_brake_req,
  output logic                    coast_req,
  output logic                    quick_stop_req,
  output logic                    freeze_req,
  output logic                    start_req,
  output logic                    fault_reset_req,
  output logic                    param_wr,
  output logic                    param_rd,
  output logic [15:0]             param_num,
  output logic [15:0]             param_index,
  output logic [15:0]             param_wdata,
  output logic                    param_nvm,
  input  wire logic               param_rd_ack,
  input  wire logic [15:0]        param_rd_data
);

  // Every decode below assumes a 16-bit data address.
  if (ADDR_W != 16) begin : g_addr_w_check
    $error("dmdm_map serves 16-bit data addresses only");
  end

  // ********************************************************************
  // Address decoding
  // ********************************************************************

  function automatic dmdm_coil_t coil_decode(input logic [15:0] a);
    if (a <= `DMDM_COIL_CMD_LAST) begin
      return DMDM_C_CMD;
    end else if (a <= `DMDM_COIL_REF_LAST) begin
      return DMDM_C_REF;
    end else if (a <= `DMDM_COIL_STAT_LAST) begin
      return DMDM_C_STAT;
    end else if (a <= `DMDM_COIL_ACT_LAST) begin
      return DMDM_C_ACT;
    end else if (a == `DMDM_COIL_STORE) begin
      return DMDM_C_STORE;
    end else begin
      return DMDM_C_NONE;
    end
  endfunction

  function automatic dmdm_hold_t hold_decode(input logic [15:0] a);
    logic [16:0] n;
    // The register number is one above the zero-based data address.
    n = {1'b0, a} + 17'd1;
    if (n == `DMDM_REG_LAST_ERROR) begin
      return DMDM_H_ERR;
    end else if (n == `DMDM_REG_ARRAY_INDEX) begin
      return DMDM_H_IDX;
    end else if (n == `DMDM_REG_CMD_WORD) begin
      return DMDM_H_CMD;
    end else if (n == `DMDM_REG_BUS_REF) begin
      return DMDM_H_REF;
    end else if (n == `DMDM_REG_STATUS) begin
      return DMDM_H_STAT;
    end else if (n == `DMDM_REG_ACTUAL) begin
      return DMDM_H_ACT;
    end else if (n >= `DMDM_REG_PARAM_FIRST && n <= `DMDM_REG_PARAM_LAST
                 && (n % `DMDM_PARAM_STEP) == 17'd0) begin
      return DMDM_H_PARAM;
    end else begin
      return DMDM_H_NONE;
    end
  endfunction

  // ********************************************************************
  // Drive values seen by the master
  // ********************************************************************

  logic [15:0] status_word;
  logic [15:0] actual_value;

  // Unused status positions always read as zero.
  always_comb begin
    status_word = {thermal_warning, current_limit, voltage_warning, 1'b0,
                   running, in_freq_range, auto_mode, at_reference,
                   warning, 3'b000, alarm, safety_closed, drive_ready,
                   control_ready};
  end

  always_comb begin
    actual_value = closed_loop ? feedback_value : output_frequency;
  end

  // ********************************************************************
  // Access sequencing and register state
  // ********************************************************************

  dmdm_state_t state;
  dmdm_state_t next_state;
  logic        store_bit;
  logic        next_store_bit;
  logic [15:0] last_error;
  logic [15:0] next_last_error;
  logic [15:0] array_index;
  logic [15:0] next_array_index;
  logic [15:0] cmd_reg;
  logic [15:0] next_cmd_reg;
  logic [15:0] ref_reg;
  logic [15:0] next_ref_reg;
  logic        next_resp_valid;
  logic [15:0] next_resp_rdata;
  logic        next_resp_reserved;
  logic        next_param_wr;
  logic        next_param_rd;
  logic [15:0] next_param_num;
  logic [15:0] next_param_wdata;
  logic        next_param_nvm;
  dmdm_coil_t  coil_sel;
  dmdm_hold_t  hold_sel;
  logic [3:0]  bit_sel;
  logic [16:0] reg_num;

  assign req_ready    = (state == DMDM_IDLE);

  always_comb begin
    coil_sel = coil_decode(req_addr);
    hold_sel = hold_decode(req_addr);
    bit_sel  = req_addr[3:0];
    reg_num  = {1'b0, req_addr} + 17'd1;
  end

  always_comb begin
    next_state         = state;
    next_store_bit     = store_bit;
    next_last_error    = last_error;
    next_array_index   = array_index;
    next_cmd_reg       = cmd_reg;
    next_ref_reg       = ref_reg;
    next_resp_valid    = 1'b0;
    next_resp_rdata    = resp_rdata;
    next_resp_reserved = resp_reserved;
    next_param_wr      = 1'b0;
    next_param_rd      = 1'b0;
    next_param_num     = param_num;
    next_param_wdata   = param_wdata;
    next_param_nvm     = param_nvm;
    // Error capture runs in every state, so no code is lost during a parameter read.
    if (error_valid) begin
      next_last_error = error_code;
    end
    case (state)
      DMDM_IDLE: begin
        if (req_valid) begin
          next_resp_rdata    = 16'h0000;
          next_resp_reserved = 1'b0;
          if (!req_holding) begin
            next_resp_valid = 1'b1;
            case (coil_sel)
              DMDM_C_CMD: begin
                next_resp_rdata[0] = cmd_reg[bit_sel];
                if (req_write) begin
                  next_cmd_reg[bit_sel] = req_wdata[0];
                end
              end
              DMDM_C_REF: begin
                next_resp_rdata[0] = ref_reg[bit_sel];
                if (req_write) begin
                  next_ref_reg[bit_sel] = req_wdata[0];
                end
              end
              DMDM_C_STAT: begin
                next_resp_rdata[0] = status_word[bit_sel];
              end
              DMDM_C_ACT: begin
                next_resp_rdata[0] = actual_value[bit_sel];
              end
              DMDM_C_STORE: begin
                next_resp_rdata[0] = store_bit;
                if (req_write) begin
                  next_store_bit = req_wdata[0];
                end
              end
              default: begin
                next_resp_reserved = 1'b1;
              end
            endcase
          end else begin
            case (hold_sel)
              DMDM_H_ERR: begin
                next_resp_valid = 1'b1;
                next_resp_rdata = last_error;
              end
              DMDM_H_IDX: begin
                next_resp_valid = 1'b1;
                next_resp_rdata = array_index;
                if (req_write) begin
                  next_array_index = req_wdata;
                end
              end
              // A holding write replaces the whole command or reference word.
              DMDM_H_CMD: begin
                next_resp_valid = 1'b1;
                next_resp_rdata = cmd_reg;
                if (req_write) begin
                  next_cmd_reg = req_wdata;
                end
              end
              DMDM_H_REF: begin
                next_resp_valid = 1'b1;
                next_resp_rdata = ref_reg;
                if (req_write) begin
                  next_ref_reg = req_wdata;
                end
              end
              DMDM_H_STAT: begin
                next_resp_valid = 1'b1;
                next_resp_rdata = status_word;
              end
              DMDM_H_ACT: begin
                next_resp_valid = 1'b1;
                next_resp_rdata = actual_value;
              end
              DMDM_H_PARAM: begin
                next_param_num   = 16'(reg_num / `DMDM_PARAM_STEP);
                next_param_wdata = req_wdata;
                next_param_nvm   = store_bit;
                if (req_write) begin
                  next_param_wr   = 1'b1;
                  next_resp_valid = 1'b1;
                  next_resp_rdata = req_wdata;
                end else begin
                  next_param_rd = 1'b1;
                  next_state    = DMDM_PARAM_WAIT;
                end
              end
              default: begin
                next_resp_valid    = 1'b1;
                next_resp_reserved = 1'b1;
              end
            endcase
          end
        end
      end
      // Ready stays low until the store answers. There is no timeout here.
      DMDM_PARAM_WAIT: begin
        if (param_rd_ack) begin
          next_resp_valid = 1'b1;
          next_resp_rdata = param_rd_data;
          next_state      = DMDM_IDLE;
        end
      end
      default: begin
        next_state = DMDM_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state         <= DMDM_IDLE;
      store_bit     <= 1'b0;
      last_error    <= `DMDM_RST_ERROR;
      array_index   <= `DMDM_RST_INDEX;
      cmd_reg       <= `DMDM_RST_CMD_WORD;
      ref_reg       <= `DMDM_RST_BUS_REF;
      resp_valid    <= 1'b0;
      resp_rdata    <= 16'h0000;
      resp_reserved <= 1'b0;
      param_wr      <= 1'b0;
      param_rd      <= 1'b0;
      param_num     <= 16'h0000;
      param_wdata   <= 16'h0000;
      param_nvm     <= 1'b0;
    end else begin
      state         <= next_state;
      store_bit     <= next_store_bit;
      last_error    <= next_last_error;
      array_index   <= next_array_index;
      cmd_reg       <= next_cmd_reg;
      ref_reg       <= next_ref_reg;
      resp_valid    <= next_resp_valid;
      resp_rdata    <= next_resp_rdata;
      resp_reserved <= next_resp_reserved;
      param_wr      <= next_param_wr;
      param_rd      <= next_param_rd;
      param_num     <= next_param_num;
      param_wdata   <= next_param_wdata;
      param_nvm     <= next_param_nvm;
    end
  end

  // ********************************************************************
  // Drive control outputs
  // ********************************************************************

  // Stop requests are active when their command bit is zero.
  always_comb begin
    command_word    = cmd_reg;
    speed_reference = ref_reg;
    param_index     = array_index;
    preset_ref_sel  = cmd_reg[`DMDM_CMD_PRESET_LO +: 2];
    setup_sel       = cmd_reg[`DMDM_CMD_SETUP_LO +: 2];
    dc_brake_req    = ~cmd_reg[`DMDM_CMD_DC_BRAKE];
    coast_req       = ~cmd_reg[`DMDM_CMD_COAST];
    quick_stop_req  = ~cmd_reg[`DMDM_CMD_QSTOP];
    freeze_req      = ~cmd_reg[`DMDM_CMD_FREEZE];
    start_req       = cmd_reg[`DMDM_CMD_START];
    fault_reset_req = cmd_reg[`DMDM_CMD_RESET];
  end

endmodule

// *** tb/dmdm_props.sv ***
`timescale 1ns/1ps
// ****************************************
// Access map checker.
// ****************************************
module dmdm_props
  import dmdm_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  input wire logic              clk,
  input wire logic              reset,
  input wire logic              req_valid,
  input wire logic              req_ready,
  input wire logic              req_holding,
  input wire logic              req_write,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [15:0]       req_wdata,
  input wire logic              resp_valid,
  input wire logic [15:0]       resp_rdata,
  input wire logic              resp_reserved,
  input wire logic [15:0]       command_word,
  input wire logic [15:0]       speed_reference,
  input wire logic [1:0]        preset_ref_sel,
  input wire logic [1:0]        setup_sel,
  input wire logic              dc_brake_req,
  input wire logic              coast_req,
  input wire logic              quick_stop_req,
  input wire logic              freeze_req,
  input wire logic              start_req,
  input wire logic              fault_reset_req,
  input wire logic              param_wr,
  input wire logic              param_rd,
  input wire logic [15:0]       param_num,
  input wire logic              param_rd_ack,
  input wire logic [15:0]       param_rd_data
);
  logic take;
  assign take = req_valid && req_ready;
  default clocking dcb @(posedge clk); endclocking
  default disable iff (reset);

  a_coil_cmd_write: assert property (take && !req_holding && req_write && req_addr < 16
    |=> resp_valid && command_word[$past(req_addr[3:0])] == $past(req_wdata[0]))
    else $error("coil write missed the command word");
  a_stop_inverse: assert property (dc_brake_req == !command_word[2]
    && coast_req == !command_word[3] && quick_stop_req == !command_word[4]
    && freeze_req == !command_word[5]) else $error("stop request polarity wrong");
  a_start_reset: assert property ({fault_reset_req, start_req} == command_word[7:6])
    else $error("start or fault reset request wrong");
  a_sel_fields: assert property ({setup_sel, preset_ref_sel}
    == {command_word[14:13], command_word[1:0]}) else $error("selector field wrong");
  a_ref_hold_write: assert property (take && req_holding && req_write
    && req_addr == 16'd50009 |=> speed_reference == $past(req_wdata))
    else $error("reference register write lost");
  a_upper_coil_ro: assert property (take && !req_holding && req_write && req_addr >= 32
    |=> $stable(command_word) && $stable(speed_reference))
    else $error("read-only coil write changed control");
  a_param_number: assert property (take && req_holding && req_write && req_addr >= 9
    && req_addr <= 49989 && (req_addr + 1) % 10 == 0
    |=> param_wr && param_num == ($past(req_addr) + 1) / 10)
    else $error("parameter number wrong");
  a_wait_ready: assert property (param_rd |-> $fell(req_ready))
    else $error("ready not dropped for parameter read");
  a_ack_answer: assert property (param_rd_ack && !req_ready
    |=> resp_valid && resp_rdata == $past(param_rd_data))
    else $error("parameter read answer wrong");
  a_reserved_coil: assert property (take && !req_holding && !req_write && req_addr > 64
    |=> resp_valid && resp_reserved && resp_rdata == 16'h0000)
    else $error("reserved coil not zero");

  c_hold_write: cover property (take && req_holding && req_write);
  c_param_ack: cover property (param_rd_ack);
  c_reserved: cover property (resp_valid && resp_reserved);
endmodule

// *** tb/dmdm_store.sv ***
`timescale 1ns/1ps
// ****************************************
// Parameter store model.
// ****************************************
module dmdm_store
  import dmdm_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        param_wr,
  input  wire logic        param_rd,
  input  wire logic [15:0] param_num,
  input  wire logic [15:0] param_index,
  input  wire logic [15:0] param_wdata,
  input  wire logic        param_nvm,
  output logic             param_rd_ack,
  output logic [15:0]      param_rd_data
);
  logic [15:0] ram [int];
  logic [15:0] nvm [int];
  int          lag = 0;
  int          key;
  initial begin
    param_rd_ack = 1'b0;
    param_rd_data = 16'h5a5a;
  end
  always @(posedge clk) begin
    if (param_wr) begin
      ram[param_num] = param_wdata;
      if (param_nvm) nvm[param_num] = param_wdata;
    end
  end
  // The read data line is driven inverted once the answer cycle is over.
  always @(posedge clk) begin
    if (param_rd) begin
      key = param_num;
      repeat (lag) @(posedge clk);
      #1;
      param_rd_ack = 1'b1;
      param_rd_data = (ram.exists(key) ? ram[key] : 16'h0000) ^ param_index;
      @(posedge clk);
      #1;
      param_rd_ack = 1'b0;
      param_rd_data = ~param_rd_data;
    end
  end
endmodule

// *** tb/drive_modbus_data_map_tb.sv ***
`timescale 1ns/1ps
`define CHK(got, exp) begin \
  tests_run++; \
  if ((got) !== (exp)) begin \
    err_count++; \
    $display("MISMATCH at %0t got %h exp %h", $time, (got), (exp)); \
  end \
end
module drive_modbus_data_map_tb
  import dmdm_pkg::*;
;
  logic        clk = 1'b0, reset = 1'b1, closed_loop = 1'b0, error_valid = 1'b0;
  logic        req_valid = 1'b0, req_holding = 1'b0, req_write = 1'b0;
  logic [15:0] req_addr = 16'h0000, req_wdata = 16'h0000, st = 16'h0000;
  logic [15:0] output_frequency = 16'h0000, feedback_value = 16'h0000, error_code = 16'h0000;
  logic        req_ready, resp_valid, resp_reserved, param_wr, param_rd, param_nvm, param_rd_ack;
  logic        dc_brake_req, coast_req, quick_stop_req, freeze_req, start_req, fault_reset_req;
  logic [1:0]  preset_ref_sel, setup_sel;
  logic [15:0] resp_rdata, command_word, speed_reference, param_num, param_index, param_wdata;
  logic [15:0] param_rd_data, cw, rf, ix, pv, pq, pr, e16;
  logic [17:0] exp_q[$];
  logic [17:0] note;
  logic [16:0] rsv [6] = '{17'h10000, 17'h10007, 17'h1000a, 17'h1c350, 17'h103e8, 17'h00041};
  logic [31:0] seed = 32'd44;
  int          err_count = 0, tests_run = 0, cycles = 0;

  always #2 clk = ~clk;

  dmdm_map #(.ADDR_W(16)) DUT (
    .clk, .reset, .req_valid, .req_ready, .req_holding, .req_write, .req_addr, .req_wdata,
    .resp_valid, .resp_rdata, .resp_reserved,
    .control_ready(st[0]), .drive_ready(st[1]), .safety_closed(st[2]), .alarm(st[3]),
    .warning(st[7]), .at_reference(st[8]), .auto_mode(st[9]), .in_freq_range(st[10]),
    .running(st[11]), .voltage_warning(st[13]), .current_limit(st[14]),
    .thermal_warning(st[15]), .closed_loop, .output_frequency, .feedback_value,
    .error_valid, .error_code, .command_word, .speed_reference, .preset_ref_sel, .setup_sel,
    .dc_brake_req, .coast_req, .quick_stop_req, .freeze_req, .start_req, .fault_reset_req,
    .param_wr, .param_rd, .param_num, .param_index, .param_wdata, .param_nvm,
    .param_rd_ack, .param_rd_data
  );
  dmdm_store u_store (.clk, .param_wr, .param_rd, .param_num, .param_index, .param_wdata,
    .param_nvm, .param_rd_ack, .param_rd_data);

  function automatic logic [15:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction
  // The request is held until an edge sees ready high.
  task automatic acc(input logic h, w, input logic [15:0] a, d, input logic [17:0] e);
    while (req_ready !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    req_valid = 1'b1;
    req_holding = h;
    req_write = w;
    req_addr = a;
    req_wdata = d;
    exp_q.push_back(e);
    @(posedge clk);
    #1;
  endtask
  task automatic rd(input logic h, input logic [15:0] a, input logic [16:0] x);
    acc(h, 1'b0, a, 16'h0000, {1'b1, x});
  endtask
  task automatic wr(input logic h, input logic [15:0] a, d);
    acc(h, 1'b1, a, d, 18'h00000);
  endtask
  task automatic cyc(input int n);
    req_valid = 1'b0;
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic complete_run();
    `CHK(exp_q.size(), 0)
    if (err_count == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    if (resp_valid === 1'b1) begin
      `CHK(exp_q.size() > 0, 1'b1)
      note = exp_q.pop_front();
      if (note[17]) `CHK({resp_reserved, resp_rdata}, note[16:0])
    end
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      complete_run();
    end
  end

  initial begin
    repeat (16) @(posedge clk);
    #1;
    reset = 1'b0;
    `CHK({dc_brake_req, coast_req, quick_stop_req, freeze_req}, 4'hf)
    cw = rnd();
    for (int i = 0; i < 16; i++) wr(1'b0, 16'(i), {15'h0, cw[i]});
    wr(1'b0, 16'h0020, ~cw);
    wr(1'b0, 16'h0050, ~cw);
    for (int i = 0; i < 16; i++) rd(1'b0, 16'(i), {16'h0, cw[i]});
    cyc(2);
    `CHK(command_word, cw)
    `CHK({setup_sel, preset_ref_sel}, {cw[14:13], cw[1:0]})
    `CHK({dc_brake_req, coast_req, quick_stop_req, freeze_req}, ~{cw[2], cw[3], cw[4], cw[5]})
    `CHK({fault_reset_req, start_req}, cw[7:6])
    rf = rnd();
    for (int i = 0; i < 16; i++) wr(1'b0, 16'(16 + i), {15'h0, rf[i]});
    rd(1'b1, 16'd50009, {1'b0, rf});
    rf = rnd();
    wr(1'b1, 16'd50009, rf);
    rd(1'b0, 16'd16, {16'h0, rf[0]});
    cw = rnd();
    wr(1'b1, 16'd49999, cw);
    rd(1'b0, 16'h0002, {16'h0, cw[2]});
    rd(1'b1, 16'd49999, {1'b0, cw});
    st = rnd();
    output_frequency = rnd();
    feedback_value = rnd();
    e16 = st & 16'hef8f;
    rd(1'b1, 16'd50199, {1'b0, e16});
    wr(1'b1, 16'd50199, 16'hffff);
    for (int i = 0; i < 16; i++) begin
      rd(1'b0, 16'(32 + i), {16'h0, e16[i]});
      rd(1'b0, 16'(48 + i), {16'h0, output_frequency[i]});
    end
    rd(1'b1, 16'd50209, {1'b0, output_frequency});
    closed_loop = 1'b1;
    rd(1'b1, 16'd50209, {1'b0, feedback_value});
    error_code = rnd();
    error_valid = 1'b1;
    cyc(1);
    error_valid = 1'b0;
    wr(1'b1, 16'd6, 16'h1234);
    rd(1'b1, 16'd6, {1'b0, error_code});
    ix = rnd();
    wr(1'b1, 16'd8, ix);
    rd(1'b1, 16'd8, {1'b0, ix});
    wr(1'b0, 16'd64, 16'h0000);
    pv = rnd();
    acc(1'b1, 1'b1, 16'd9, pv, {2'b10, pv});
    cyc(2);
    `CHK(u_store.ram[1], pv)
    `CHK(u_store.nvm.exists(1) != 0, 1'b0)
    wr(1'b0, 16'd64, 16'h0001);
    rd(1'b0, 16'd64, 17'h00001);
    pq = rnd();
    pr = rnd();
    acc(1'b1, 1'b1, 16'd49989, pq, {2'b10, pq});
    acc(1'b1, 1'b1, 16'd999, pr, {2'b10, pr});
    cyc(2);
    `CHK(u_store.nvm[4999], pq)
    `CHK(u_store.nvm[100], pr)
    `CHK(u_store.ram[100], pr)
    rd(1'b1, 16'd9, {1'b0, pv ^ ix});
    u_store.lag = 5;
    rd(1'b1, 16'd49989, {1'b0, pq ^ ix});
    rd(1'b1, 16'd999, {1'b0, pr ^ ix});
    foreach (rsv[k]) begin
      wr(rsv[k][16], rsv[k][15:0], 16'hffff);
      rd(rsv[k][16], rsv[k][15:0], 17'h10000);
    end
    cyc(12);
    `CHK(command_word, cw)
    `CHK(speed_reference, rf)
    reset = 1'b1;
    cyc(2);
    reset = 1'b0;
    `CHK({command_word, speed_reference}, 32'h00000000)
    rd(1'b1, 16'd8, 17'h00000);
    rd(1'b0, 16'd64, 17'h00000);
    cyc(2);
    complete_run();
  end
endmodule

bind dmdm_map dmdm_props #(.ADDR_W(ADDR_W)) u_props (
  .clk, .reset, .req_valid, .req_ready, .req_holding, .req_write, .req_addr, .req_wdata,
  .resp_valid, .resp_rdata, .resp_reserved, .command_word, .speed_reference,
  .preset_ref_sel, .setup_sel, .dc_brake_req, .coast_req, .quick_stop_req, .freeze_req,
  .start_req, .fault_reset_req, .param_wr, .param_rd, .param_num, .param_rd_ack,
  .param_rd_data
);
